// ==== iofe_pkg.sv ====
// package: constants, layouts and helpers of the inclinometer output field encoder
`default_nettype none
package iofe_pkg;
  // field widths
  localparam int AXIS_N = 3;
  localparam int FIELD_W = 24;
  localparam int TEMP_W = 16;
  localparam int BYTE_W = 8;
  localparam int SCNT_W = 8;
  localparam int LAT_W = 16;
  localparam int AVG_CNT_W = 16;
  // clock and sample timing
  localparam int CLK_MHZ = 250;
  localparam int US_PER_S = 1_000_000;
  localparam int SAMPLE_PERIOD_US = 500;
  localparam int SAMPLE_HZ = US_PER_S / SAMPLE_PERIOD_US;
  localparam int SAMPLE_CYC_DEF = SAMPLE_PERIOD_US * CLK_MHZ;
  localparam int LAT_UNIT_US = 1;
  localparam int LAT_UNIT_CYC = LAT_UNIT_US * CLK_MHZ;
  // acceleration lsb 2^-22 g, velocity lsb 2^-25 gs
  localparam int ACC_FRAC = 24;
  localparam int ACC_W = FIELD_W + ACC_FRAC;
  localparam int VEL_SHIFT = 3;
  localparam int VEL_GAIN_W = 18;
  localparam logic signed [VEL_GAIN_W-1:0] VEL_GAIN =
    VEL_GAIN_W'((2 ** (ACC_FRAC + VEL_SHIFT)) / SAMPLE_HZ);
  // register bus
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / BYTE_W;
  localparam int REG_STEP = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [ADDR_W-1:0] REG_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] REG_TRIM0 = 6'h04;
  localparam logic [ADDR_W-1:0] REG_STAT = 6'h10;
  localparam logic [ADDR_W-1:0] REG_FIELD0 = 6'h14;
  localparam logic [ADDR_W-1:0] REG_TEMP0 = 6'h20;
  localparam logic [ADDR_W-1:0] REG_AUX = 6'h2c;
  // control and status layout
  localparam int CTRL_W = 3;
  localparam int CTRL_INTEG_BIT = 0;
  localparam int CTRL_AUX_BIT = 1;
  localparam int CTRL_CFG_BIT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_LAT_LSB = 16;

  // apply byte enables of a write to an old register word
  function automatic logic [DATA_W-1:0] byte_merge(input logic [DATA_W-1:0] old_w,
                                                   input logic [DATA_W-1:0] new_w,
                                                   input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] r;
    r = old_w;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        r[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
      end
    end
    return r;
  endfunction

  // address a is word i of a per-axis group
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] base,
                                   input int i);
    return a == base + ADDR_W'(i * REG_STEP);
  endfunction
endpackage
`default_nettype wire

// ==== iofe_axis_if.sv ====
// interface: one axis channel between encoder top and its datapath
`default_nettype none
interface iofe_axis_if;
  import iofe_pkg::*;
  logic tick;
  logic tx;
  logic integ;
  logic [FIELD_W-1:0] comp;
  logic [FIELD_W-1:0] trim;
  logic done;
  logic [FIELD_W-1:0] field;
  modport chan (input tick, input tx, input integ, input comp, input trim,
                output done, output field);
  modport ctl (output tick, output tx, output integ, output comp, output trim,
               input done, input field);
endinterface
`default_nettype wire

// ==== iofe_tick.sv ====
// module: internal sample tick, sample counter and latency timer
`default_nettype none
module iofe_tick #(
  parameter int SAMPLE_CYC = iofe_pkg::SAMPLE_CYC_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick,
  output logic [iofe_pkg::SCNT_W-1:0] count,
  output logic [iofe_pkg::LAT_W-1:0] lat_us
);
  import iofe_pkg::*;
  localparam int DIV_W = $clog2(SAMPLE_CYC);
  localparam int US_W = $clog2(LAT_UNIT_CYC);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [US_W-1:0] us;
    logic [LAT_W-1:0] lat;
    logic [SCNT_W-1:0] count;
    logic tick;
  } iofe_tick_state_t;

  iofe_tick_state_t s_reg, s_next;

  // one tick per sample period; latency counts whole microseconds since it
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.div == DIV_W'(SAMPLE_CYC - 1)) begin
      s_next.div = '0;
      s_next.tick = 1'b1;
      s_next.count = s_reg.count + 1'b1; // [R7] [R8] wraps 255 to 0 silently
      s_next.us = '0;
      s_next.lat = '0;
    end else begin
      s_next.div = s_reg.div + 1'b1;
      if (s_reg.us == US_W'(LAT_UNIT_CYC - 1)) begin
        s_next.us = '0;
        if (s_reg.lat != '1) begin
          s_next.lat = s_reg.lat + 1'b1; // [R9] saturates rather than wrapping
        end
      end else begin
        s_next.us = s_reg.us + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
  assign count = s_reg.count;
  assign lat_us = s_reg.lat;
endmodule
`default_nettype wire

// ==== iofe_axis.sv ====
// module: one inclinometer axis: trim add, averaging with divider, velocity integral
`default_nettype none
module iofe_axis #(
  parameter int CNT_W = iofe_pkg::AVG_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  iofe_axis_if.chan ch
);
  import iofe_pkg::*;
  localparam int SUM_W = FIELD_W + CNT_W;
  localparam int STEP_W = $clog2(SUM_W + 1);
  localparam int PROD_W = FIELD_W + VEL_GAIN_W;

  typedef struct packed {
    logic signed [SUM_W-1:0] sum;
    logic [CNT_W-1:0] cnt;
    logic signed [ACC_W-1:0] acc;
    logic busy;
    logic neg;
    logic integ;
    logic hold;
    logic done;
    logic [SUM_W-1:0] num;
    logic [CNT_W:0] rem;
    logic [CNT_W-1:0] den;
    logic [STEP_W-1:0] step;
    logic [FIELD_W-1:0] ivel;
    logic [FIELD_W-1:0] field;
  } iofe_axis_state_t;

  iofe_axis_state_t s_reg, s_next;

  // value plus trim, clamped so an overflowing sum saturates instead of wrapping to the other sign
  function automatic logic signed [FIELD_W-1:0] sat_add(input logic [FIELD_W-1:0] a,
                                                        input logic [FIELD_W-1:0] b);
    logic signed [FIELD_W:0] t;
    t = signed'({a[FIELD_W-1], a}) + signed'({b[FIELD_W-1], b});
    if (t[FIELD_W] != t[FIELD_W-1]) begin
      return t[FIELD_W] ? {1'b1, {(FIELD_W-1){1'b0}}} : {1'b0, {(FIELD_W-1){1'b1}}};
    end
    return t[FIELD_W-1:0];
  endfunction

  // accumulate, integrate, divide the window sum a bit per cycle
  always_comb begin
    logic signed [FIELD_W-1:0] adj;
    logic signed [SUM_W-1:0] adj_ext;
    logic signed [PROD_W-1:0] prod;
    logic [CNT_W:0] rem_sh;
    logic [SUM_W-1:0] quo;
    adj = sat_add(ch.comp, ch.trim); // [R10] [R11] trim shares the g lsb of the sample
    adj_ext = SUM_W'(adj);
    prod = adj * VEL_GAIN;
    rem_sh = '0;
    quo = '0;
    s_next = s_reg;
    s_next.done = 1'b0;
    if (ch.tick) begin
      s_next.acc = s_reg.acc + ACC_W'(prod); // [R2] [R15] [R4] wraps modulo field width
    end
    if (ch.tx) begin
      s_next.integ = ch.integ;
      s_next.ivel = s_next.acc[ACC_W-1 -: FIELD_W]; // [R3] [R13] lsb 2^-25
      s_next.hold = (s_reg.cnt == '0);
      s_next.neg = s_reg.sum[SUM_W-1];
      s_next.num = s_reg.sum[SUM_W-1] ? SUM_W'(-s_reg.sum) : s_reg.sum;
      s_next.den = s_reg.cnt;
      s_next.rem = '0;
      s_next.step = '0;
      s_next.busy = 1'b1;
      // a sample on the same edge opens the next window
      s_next.sum = ch.tick ? adj_ext : '0; // [R1]
      s_next.cnt = ch.tick ? CNT_W'(1) : '0;
    end else if (ch.tick && s_reg.cnt != '1) begin
      s_next.sum = s_reg.sum + adj_ext; // [R1] mean of samples since last send
      s_next.cnt = s_reg.cnt + 1'b1;
    end
    if (s_reg.busy) begin
      if (s_reg.step == STEP_W'(SUM_W)) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
        quo = s_reg.neg ? SUM_W'(-s_reg.num) : s_reg.num;
        if (s_reg.integ) begin
          s_next.field = s_reg.ivel; // [R2]
        end else if (!s_reg.hold) begin
          s_next.field = quo[FIELD_W-1:0]; // [R14] mean of 24-bit values stays in range
        end
      end else begin
        rem_sh = {s_reg.rem[CNT_W-1:0], s_reg.num[SUM_W-1]};
        s_next.num = {s_reg.num[SUM_W-2:0], 1'b0};
        if (rem_sh >= {1'b0, s_reg.den}) begin
          s_next.rem = rem_sh - {1'b0, s_reg.den};
          s_next.num[0] = 1'b1;
        end else begin
          s_next.rem = rem_sh;
        end
        s_next.step = s_reg.step + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ch.done = s_reg.done;
  assign ch.field = s_reg.field;
endmodule
`default_nettype wire

// ==== iofe_top.sv ====
// module: inclinometer output field encoder top with its register slave
`default_nettype none
// Functional notes
// [R1]: average mode sends the mean of samples since the previous transmission
// [R2]: integrated mode sends velocity integrated since power-on or reset
// [R3]: integrated velocity spans minus to plus a quarter unit, velocity encoding
// [R4]: integrated velocity wraps silently with no status flag
// [R5]: temperature per axis is 16-bit two's complement, eight fractional bits
// [R6]: auxiliary voltage is 24-bit two's complement, full scale 5 volts
// [R7]: 8-bit sample counter steps once per internal sample and is sent
// [R8]: sample counter rolls from 255 to 0 without error indication
// [R9]: latency is unsigned 16-bit, one count per microsecond
// [R10]: per-axis trim offset is added after compensation; the sum is sent
// [R11]: trim offsets are held in g for inclinometer axes in every unit
// [R12]: host changes trim offsets only while in a configuration mode
// [R13]: velocity field is 24-bit two's complement, lsb two to minus 25
// [R14]: acceleration field is 24-bit two's complement, lsb two to minus 22
// [R15]: integral register updates each sample and wraps modulo field width
module iofe_top #(
  parameter int SAMPLE_CYC = iofe_pkg::SAMPLE_CYC_DEF,
  parameter int CNT_W = iofe_pkg::AVG_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [iofe_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [iofe_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [iofe_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [iofe_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [iofe_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [iofe_pkg::AXIS_N-1:0][iofe_pkg::FIELD_W-1:0] incl_comp,
  input wire logic [iofe_pkg::AXIS_N-1:0][iofe_pkg::TEMP_W-1:0] temp_in,
  input wire logic [iofe_pkg::FIELD_W-1:0] aux_in,
  input wire logic tx_req,
  output logic sample_tick,
  output logic busy,
  output logic field_valid,
  output logic [iofe_pkg::AXIS_N-1:0][iofe_pkg::FIELD_W-1:0] incl_field,
  output logic [iofe_pkg::AXIS_N-1:0][iofe_pkg::BYTE_W-1:0] temp_high_byte,
  output logic [iofe_pkg::AXIS_N-1:0][iofe_pkg::BYTE_W-1:0] temp_low_byte,
  output logic [iofe_pkg::FIELD_W-1:0] aux_field,
  output logic [iofe_pkg::SCNT_W-1:0] sample_count,
  output logic [iofe_pkg::BYTE_W-1:0] latency_high_byte,
  output logic [iofe_pkg::BYTE_W-1:0] latency_low_byte
);
  import iofe_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [AXIS_N-1:0][FIELD_W-1:0] trim;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic tick;
    logic busy;
    logic fvalid;
    logic [AXIS_N-1:0][FIELD_W-1:0] incl;
    logic [AXIS_N-1:0][TEMP_W-1:0] temp;
    logic [FIELD_W-1:0] aux;
    logic [SCNT_W-1:0] count;
    logic [LAT_W-1:0] lat;
  } iofe_top_state_t;

  iofe_top_state_t s_reg, s_next;

  logic tick_w;
  logic [SCNT_W-1:0] count_w;
  logic [LAT_W-1:0] lat_w;
  logic tx_go;
  logic [AXIS_N-1:0] done_w;
  logic [AXIS_N-1:0][FIELD_W-1:0] field_w;

  // sample timebase, counter and latency timer
  iofe_tick #(
    .SAMPLE_CYC(SAMPLE_CYC)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_w),
    .count(count_w),
    .lat_us(lat_w)
  );

  // a request is taken only when the previous one has finished
  assign tx_go = tx_req && !s_reg.busy;

  // one datapath per inclinometer axis
  for (genvar g = 0; g < AXIS_N; g++) begin : g_axis
    iofe_axis_if ch ();
    assign ch.tick = tick_w;
    assign ch.tx = tx_go;
    assign ch.integ = s_reg.ctrl[CTRL_INTEG_BIT];
    assign ch.comp = incl_comp[g];
    assign ch.trim = s_reg.trim[g]; // [R10]
    assign done_w[g] = ch.done;
    assign field_w[g] = ch.field;
    iofe_axis #(
      .CNT_W(CNT_W)
    ) u_axis (
      .aclk(aclk),
      .aresetn(aresetn),
      .ch(ch)
    );
  end

  // register slave, side-field capture, result hand-out
  always_comb begin
    s_next = s_reg;
    s_next.fvalid = 1'b0;
    s_next.tick = tick_w;
    // write address and data taken in either order
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.awready = 1'b0;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.wready = 1'b0;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    // both halves held, no answer pending: do the write
    if (!s_reg.awready && !s_reg.wready && !s_reg.bvalid) begin
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_DECERR;
      if (s_reg.awaddr == REG_CTRL) begin
        s_next.bresp = RESP_OKAY;
        s_next.ctrl = CTRL_W'(byte_merge(DATA_W'(s_reg.ctrl), s_reg.wdata, s_reg.wstrb));
      end else if (s_reg.awaddr == REG_STAT || s_reg.awaddr == REG_AUX) begin
        s_next.bresp = RESP_SLVERR;
      end
      for (int i = 0; i < AXIS_N; i++) begin
        if (reg_hit(s_reg.awaddr, REG_FIELD0, i) || reg_hit(s_reg.awaddr, REG_TEMP0, i)) begin
          s_next.bresp = RESP_SLVERR;
        end
        if (reg_hit(s_reg.awaddr, REG_TRIM0, i)) begin
          // trims locked while streaming keep sends consistent
          if (s_reg.ctrl[CTRL_CFG_BIT]) begin
            s_next.bresp = RESP_OKAY;
            s_next.trim[i] = FIELD_W'(byte_merge(DATA_W'(s_reg.trim[i]), s_reg.wdata,
                                                 s_reg.wstrb)); // [R11]
          end else begin
            s_next.bresp = RESP_SLVERR; // [R12]
          end
        end
      end
    end
    // read: one outstanding, answered the edge after the address
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = '0;
      if (s_axi_araddr == REG_CTRL) begin
        s_next.rdata = DATA_W'(s_reg.ctrl);
      end else if (s_axi_araddr == REG_STAT) begin
        s_next.rdata[STAT_CNT_LSB +: SCNT_W] = count_w;
        s_next.rdata[STAT_BUSY_BIT] = s_reg.busy;
        s_next.rdata[STAT_LAT_LSB +: LAT_W] = lat_w;
      end else if (s_axi_araddr == REG_AUX) begin
        s_next.rdata = DATA_W'(s_reg.aux);
      end else begin
        s_next.rresp = RESP_DECERR;
      end
      for (int i = 0; i < AXIS_N; i++) begin
        if (reg_hit(s_axi_araddr, REG_TRIM0, i)) begin
          s_next.rresp = RESP_OKAY;
          s_next.rdata = DATA_W'(s_reg.trim[i]);
        end
        if (reg_hit(s_axi_araddr, REG_FIELD0, i)) begin
          s_next.rresp = RESP_OKAY;
          s_next.rdata = DATA_W'(s_reg.incl[i]);
        end
        if (reg_hit(s_axi_araddr, REG_TEMP0, i)) begin
          s_next.rresp = RESP_OKAY;
          s_next.rdata = DATA_W'(s_reg.temp[i]);
        end
      end
    end
    // side fields frozen at request match the sample counted
    if (tx_go) begin
      s_next.busy = 1'b1;
      s_next.count = count_w; // [R7]
      s_next.lat = lat_w; // [R9]
      s_next.temp = temp_in; // [R5]
      s_next.aux = s_reg.ctrl[CTRL_AUX_BIT] ? aux_in : '0; // [R6]
    end
    // axes finish together; axis 0 stands for all
    if (s_reg.busy && done_w[0]) begin
      s_next.busy = 1'b0;
      s_next.fvalid = 1'b1;
      s_next.incl = field_w; // [R1] [R2] [R14]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from state, most significant byte first
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign sample_tick = s_reg.tick;
  assign busy = s_reg.busy;
  assign field_valid = s_reg.fvalid;
  assign incl_field = s_reg.incl;
  assign aux_field = s_reg.aux;
  assign sample_count = s_reg.count;
  assign latency_high_byte = s_reg.lat[LAT_W-1 -: BYTE_W];
  assign latency_low_byte = s_reg.lat[BYTE_W-1:0];
  for (genvar t = 0; t < AXIS_N; t++) begin : g_temp
    assign temp_high_byte[t] = s_reg.temp[t][TEMP_W-1 -: BYTE_W];
    assign temp_low_byte[t] = s_reg.temp[t][BYTE_W-1:0];
  end
endmodule
`default_nettype wire

// ==== iofe_props.sv ====
// checker: timing relations at the encoder top ports
`default_nettype none
module iofe_props #(
  parameter int SAMPLE_CYC = iofe_pkg::SAMPLE_CYC_DEF,
  parameter int CNT_W = iofe_pkg::AVG_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_req,
  input wire logic busy,
  input wire logic field_valid,
  input wire logic sample_tick,
  input wire logic [iofe_pkg::AXIS_N-1:0][iofe_pkg::TEMP_W-1:0] temp_in,
  input wire logic [iofe_pkg::AXIS_N-1:0][iofe_pkg::BYTE_W-1:0] temp_high_byte,
  input wire logic [iofe_pkg::AXIS_N-1:0][iofe_pkg::BYTE_W-1:0] temp_low_byte,
  input wire logic [iofe_pkg::AXIS_N-1:0][iofe_pkg::FIELD_W-1:0] incl_field,
  input wire logic [iofe_pkg::SCNT_W-1:0] sample_count,
  input wire logic [iofe_pkg::BYTE_W-1:0] latency_high_byte,
  input wire logic [iofe_pkg::BYTE_W-1:0] latency_low_byte,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  import iofe_pkg::*;
  localparam int FV_DLY = FIELD_W + CNT_W + 2;
  typedef struct packed {
    logic seen;
    logic [31:0] gap;
  } iofe_gap_t;
  iofe_gap_t gap_reg;
  // cycles since last tick; the first tick after reset has no reference
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_reg <= '0;
    end else if (sample_tick) begin
      gap_reg <= '{seen: 1'h1, gap: 32'h0};
    end else begin
      gap_reg.gap <= gap_reg.gap + 32'h1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  tick_period_a: assert property (
    sample_tick && gap_reg.seen |-> gap_reg.gap == 32'(SAMPLE_CYC - 1))
    else $error("sample tick spacing wrong");
  field_delay_a: assert property (
    tx_req && !busy |=> busy ##FV_DLY field_valid)
    else $error("field answer late");
  field_pulse_a: assert property (field_valid |=> !field_valid)
    else $error("field valid too long");
  busy_clear_a: assert property (field_valid |-> !busy && $past(busy))
    else $error("busy not ending with field valid");
  temp_latch_a: assert property (
    tx_req && !busy |=> {temp_high_byte[0], temp_low_byte[0]} == $past(temp_in[0])
      && {temp_high_byte[2], temp_low_byte[2]} == $past(temp_in[2]))
    else $error("temp bytes not taken at request");
  word_hold_a: assert property (
    !(tx_req && !busy) |=> $stable({sample_count, latency_high_byte, latency_low_byte}))
    else $error("side word changed without request");
  incl_hold_a: assert property (
    !field_valid && $past(aresetn) |-> $stable(incl_field))
    else $error("field changed without field valid");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule
bind iofe_top iofe_props #(.SAMPLE_CYC(SAMPLE_CYC), .CNT_W(CNT_W)) iofe_props_i (
  .aclk, .aresetn, .tx_req, .busy, .field_valid, .sample_tick, .temp_in, .temp_high_byte,
  .temp_low_byte, .incl_field, .sample_count, .latency_high_byte, .latency_low_byte,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// ==== iofe_host_model.sv ====
// host model: rebuilds multi-byte fields as the receiver does
`default_nettype none
module iofe_host_model (
  input wire logic aclk,
  input wire logic field_valid,
  input wire logic [iofe_pkg::AXIS_N-1:0][iofe_pkg::BYTE_W-1:0] temp_high_byte,
  input wire logic [iofe_pkg::AXIS_N-1:0][iofe_pkg::BYTE_W-1:0] temp_low_byte,
  input wire logic [iofe_pkg::BYTE_W-1:0] latency_high_byte,
  input wire logic [iofe_pkg::BYTE_W-1:0] latency_low_byte,
  output logic [iofe_pkg::AXIS_N-1:0][iofe_pkg::TEMP_W-1:0] temp_word,
  output logic [iofe_pkg::LAT_W-1:0] lat_word
);
  timeunit 1ns;
  timeprecision 1ps;
  import iofe_pkg::*;
  // datagram taken at field valid; high byte first
  always @(posedge aclk) begin
    if (field_valid) begin
      for (int a = 0; a < AXIS_N; a++) begin
        temp_word[a] <= {temp_high_byte[a], temp_low_byte[a]};
      end
      lat_word <= {latency_high_byte, latency_low_byte};
    end
  end
endmodule
`default_nettype wire

// ==== imu_output_field_encoder_tb.sv ====
// testbench: encoder top, register traffic, host model
`default_nettype none
module imu_output_field_encoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iofe_pkg::*;
  localparam int SCYC = 300;
  // 2 g for one sample at lsb 2^-25 gs, with the gain truncated
  localparam int VSTEP = 33554;
  `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic tx_req, sample_tick, busy, field_valid;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [STRB_W-1:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [AXIS_N-1:0][FIELD_W-1:0] incl_comp, incl_field, fv;
  logic [AXIS_N-1:0][TEMP_W-1:0] temp_in, temp_word;
  logic [AXIS_N-1:0][BYTE_W-1:0] temp_high_byte, temp_low_byte;
  logic [FIELD_W-1:0] aux_in, aux_field;
  logic [SCNT_W-1:0] sample_count;
  logic [BYTE_W-1:0] latency_high_byte, latency_low_byte;
  logic [LAT_W-1:0] lat_word;
  int n_fail = 0, cmp_count = 0;
  int n_tick = 0, tick_at = 0;
  typedef struct packed {
    logic [FIELD_W-1:0] comp;
    logic [FIELD_W-1:0] trim;
    logic [TEMP_W-1:0] temp;
    logic [FIELD_W-1:0] aux;
    logic aux_en;
    logic [9:0] dly;
    logic [LAT_W-1:0] lat;
  } iofe_row_t;
  iofe_row_t rows [3] = '{
    '{24'h100000, 24'h000123, 16'h1980, 24'h7fffff, 1'h1, 10'h064, 16'h0000},
    '{24'hf00000, 24'hffff00, 16'hf380, 24'h800000, 1'h1, 10'h10e, 16'h0001},
    '{24'h3ffff0, 24'h000010, 16'h0001, 24'h123456, 1'h0, 10'h005, 16'h0000}};

  iofe_top #(.SAMPLE_CYC(SCYC), .CNT_W(AVG_CNT_W)) iofe_top_i (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .incl_comp,
    .temp_in, .aux_in, .tx_req, .sample_tick, .busy, .field_valid, .incl_field,
    .temp_high_byte, .temp_low_byte, .aux_field, .sample_count, .latency_high_byte,
    .latency_low_byte);
  iofe_host_model iofe_host_model_i (.aclk, .field_valid, .temp_high_byte, .temp_low_byte,
    .latency_high_byte, .latency_low_byte, .temp_word, .lat_word);

  // clock and sample tick tally
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (sample_tick) n_tick <= n_tick + 1;
  end

  // write: address and data together, each dropped once taken; bready late
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // request d cycles after a tick, never on a sample edge
  task automatic req(input int d);
    do @(posedge aclk); while (!sample_tick);
    repeat (d) @(posedge aclk);
    tx_req <= 1'h1;
    tick_at = n_tick;
    @(posedge aclk);
    tx_req <= 1'h0;
    for (int i = 0; i < 60 && !field_valid; i++) @(posedge aclk);
    @(posedge aclk);
  endtask
  task automatic results();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    logic [1:0] r;
    logic [DATA_W-1:0] v;
    logic [SCNT_W-1:0] c0;
    int t0;
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, tx_req} = '0;
    s_axi_rready = 1'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, incl_comp, temp_in, aux_in} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    // table rows: average, trims, temperature, aux, latency
    foreach (rows[i]) begin
      wr(REG_CTRL, 32'h4, r);
      for (int a = 0; a < AXIS_N; a++) begin
        wr(REG_TRIM0 + ADDR_W'(a * REG_STEP), 32'(rows[i].trim), r);
        `CHK(r, RESP_OKAY)
        incl_comp[a] <= rows[i].comp + FIELD_W'(a);
        temp_in[a] <= rows[i].temp + TEMP_W'(a);
      end
      wr(REG_CTRL, {30'h0, rows[i].aux_en, 1'h0}, r);
      aux_in <= rows[i].aux;
      req(int'(rows[i].dly));
      req(int'(rows[i].dly));
      for (int a = 0; a < AXIS_N; a++) begin
        `CHK(incl_field[a], rows[i].comp + FIELD_W'(a) + rows[i].trim)
        `CHK(temp_word[a], rows[i].temp + TEMP_W'(a))
      end
      `CHK(aux_field, rows[i].aux_en ? rows[i].aux : 24'h0)
      `CHK(lat_word, rows[i].lat)
      rd(REG_FIELD0, v, r);
      `CHK(v, {8'h0, rows[i].comp + rows[i].trim})
    end
    // mid-run reset, reset values, refused accesses
    incl_comp <= '0;
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    `CHK({s_axi_awready, s_axi_wready, s_axi_arready, busy, field_valid}, 5'h1c)
    rd(REG_CTRL, v, r);
    `CHK(v, 32'h0)
    wr(REG_TRIM0, 32'h000555, r);
    `CHK(r, RESP_SLVERR)
    rd(REG_TRIM0, v, r);
    `CHK(v, 32'h0)
    wr(REG_STAT, 32'h1, r);
    `CHK(r, RESP_SLVERR)
    rd(6'h30, v, r);
    `CHK({r, v}, {RESP_DECERR, 32'h0})
    // integral restarts at zero, falls a fixed step per sample, wraps
    wr(REG_CTRL, 32'h1, r);
    req(2);
    `CHK(incl_field, '0)
    wr(REG_CTRL, 32'h4, r);
    for (int a = 0; a < AXIS_N; a++) begin
      wr(REG_TRIM0 + ADDR_W'(a * REG_STEP), 32'h00c00000, r);
    end
    wr(REG_CTRL, 32'h1, r);
    incl_comp <= {AXIS_N{24'hc00000}};
    req(2);
    repeat (2) begin
      fv = incl_field;
      c0 = sample_count;
      t0 = tick_at;
      repeat (130) do @(posedge aclk); while (!sample_tick);
      req(2);
      for (int a = 0; a < AXIS_N; a++) begin
        `CHK(incl_field[a], fv[a] - FIELD_W'(VSTEP * (tick_at - t0)))
      end
      `CHK(sample_count, c0 + SCNT_W'(tick_at - t0))
    end
    results();
  end

  // watchdog: run needs about 82000 cycles
  initial begin
    repeat (100000) @(posedge aclk);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
